/* core/four_channel_dma_control.v */
// control logic of a four-channel dma engine with register port
`timescale 1ns/10ps
`include "four_channel_dma_control_defines.vh"

module four_channel_dma_control #(
  parameter COUNT_W = 16
) (
  input  wire               sys_clk,
  input  wire               reset_n,
  input  wire [7:0]         regAddr,
  input  wire [31:0]        regWdata,
  input  wire               regWrite,
  input  wire               regRead,
  output reg  [31:0]        regRdata_r,
  input  wire [3:0]         periphXferReq,
  output reg                xferBusy_r,
  output reg  [1:0]         xferChannel_r,
  output reg                xferTwoCycle_r,
  output reg                xferPhase_r,
  output reg                xferStrobe_r,
  output reg                xferLast_r,
  output reg  [3:0]         strobeWidth_r,
  output reg  [3:0]         transferEndPulse_r,
  output reg                irq_r
);

  localparam ST_IDLE = 1'b0;           // waiting for a channel to ask
  localparam ST_RUN  = 1'b1;           // strobe phase in progress

  // per-channel state
  reg  [COUNT_W-1:0] progCount_r [0:3]; // programmed count, transfers minus one
  reg  [COUNT_W-1:0] remCount_r  [0:3]; // remaining count of running sequence
  reg  [1:0]         mode_r      [0:3]; // transfer mode per channel
  reg  [3:0]         enable_r;          // channel enable bits
  reg  [3:0]         twoCycle_r;        // 1: 2-cycle, 0: flyby
  reg  [3:0]         swTrig_r;          // pending software trigger
  reg  [3:0]         stepArm_r;         // request edge waiting in step mode
  reg  [3:0]         blockRun_r;        // block sequence started
  reg  [3:0]         newSeq_r;          // next enable starts a fresh count
  reg  [3:0]         tcFlag_r;          // terminal-count flags
  reg  [3:0]         reqPrev_r;         // request delayed for edge detect

  // shared state
  reg  [7:0]         waitSet_r;         // system wait setting
  reg  [3:0]         intStat_r;         // sticky end-of-transfer status
  reg  [3:0]         intMask_r;         // 1 lets a status bit interrupt
  reg                state_r;           // engine state
  reg  [3:0]         strobeCnt_r;       // clocks of current strobe phase

  // decode and arbitration
  reg  [1:0]         wordChan;          // channel addressed by the word
  reg                ctrlHit;           // address hits a control word
  reg                countHit;          // address hits a count word
  reg  [3:0]         want;              // channels ready for a transfer
  reg                grantAny;          // some channel wants the bus
  reg  [1:0]         grantIdx;          // winning channel
  reg                trig;              // request term of one channel
  reg                initWrite;         // initialise bit written this cycle
  reg                startOk;           // a transfer begins this cycle
  reg                xferDone;          // last strobe clock of a transfer
  reg                abortRun;          // initialise kills running transfer
  reg  [3:0]         strobeNxt;         // decoded strobe width
  reg  [31:0]        readNxt;           // read data for next cycle
  wire [3:0]         reqEdge;           // rising request edges

  integer i;                            // loop index, comb
  integer j;                            // loop index, clocked

  assign reqEdge = periphXferReq & ~reqPrev_r;

  // address decode; only aligned words are mapped
  always @* begin
    wordChan = regAddr[3:2];
    ctrlHit  = (regAddr & `DMA_CHAN_MASK) == `DMA_CTRL_BASE;
    countHit = (regAddr & `DMA_CHAN_MASK) == `DMA_COUNT_BASE;
    initWrite = regWrite & ctrlHit & regWdata[`CTL_INIT_BIT];
  end

  // decode the wait setting into the strobe width
  always @* begin
    case (waitSet_r)
      `WAIT_CODE_2CLK: strobeNxt = `STROBE_2CLK;
      `WAIT_CODE_3CLK: strobeNxt = `STROBE_3CLK;
      `WAIT_CODE_4CLK: strobeNxt = `STROBE_4CLK;
      `WAIT_CODE_5CLK: strobeNxt = `STROBE_5CLK;
      `WAIT_CODE_8CLK: strobeNxt = `STROBE_8CLK;
      // undefined codes fall back to the slowest, safe width
      default:         strobeNxt = `STROBE_8CLK;
    endcase
  end

  // which channels are ready, fixed priority with channel 0 highest
  always @* begin
    want = 4'h0;
    trig = 1'b0;
    grantIdx = 2'h0;
    for (i = 0; i < 4; i = i + 1) begin
      if (mode_r[i] == `DMA_MODE_STEP)
        trig = stepArm_r[i];
      else
        trig = periphXferReq[i];
      want[i] = enable_r[i] & (blockRun_r[i] | swTrig_r[i] | trig);
    end
    for (i = 3; i >= 0; i = i - 1) begin
      if (want[i])
        grantIdx = i[1:0];
    end
    grantAny = |want;
  end

  // engine timing terms
  always @* begin
    // an initialise of the channel about to start wins over the start
    startOk  = (state_r == ST_IDLE) & grantAny & ~(initWrite & (grantIdx == wordChan));
    abortRun = (state_r == ST_RUN) & initWrite & (xferChannel_r == wordChan);
    xferDone = (state_r == ST_RUN) & ~abortRun & (strobeCnt_r >= strobeWidth_r)
             & (~xferTwoCycle_r | xferPhase_r);
  end

  // read mux; reading has its side effect in the clocked process
  always @* begin
    readNxt = 32'h0000_0000;
    if (ctrlHit) begin
      readNxt[`CTL_ENABLE_BIT] = enable_r[wordChan];
      readNxt[`CTL_SWTRIG_BIT] = swTrig_r[wordChan];
      readNxt[`CTL_MODE_HI:`CTL_MODE_LO] = mode_r[wordChan];
      readNxt[`CTL_TWOCYC_BIT] = twoCycle_r[wordChan];
      readNxt[`CTL_TC_BIT] = tcFlag_r[wordChan];
    end else if (countHit) begin
      readNxt[15:0]  = remCount_r[wordChan];
      readNxt[31:16] = progCount_r[wordChan];
    end else if (regAddr == `DMA_RESTART_ADDR) begin
      readNxt[3:0] = enable_r;
    end else if (regAddr == `DMA_WAIT_ADDR) begin
      readNxt[7:0] = waitSet_r;
    end else if (regAddr == `DMA_STAT_ADDR) begin
      readNxt[3:0] = intStat_r;
    end else if (regAddr == `DMA_MASK_ADDR) begin
      readNxt[3:0] = intMask_r;
    end
  end

  // all state; later assignments in this process take priority
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (j = 0; j < 4; j = j + 1) begin
        progCount_r[j] <= {COUNT_W{1'b0}};
        remCount_r[j]  <= {COUNT_W{1'b0}};
        mode_r[j]      <= `DMA_MODE_SINGLE;
      end
      enable_r       <= 4'h0;
      twoCycle_r     <= 4'h0;
      swTrig_r       <= 4'h0;
      stepArm_r      <= 4'h0;
      blockRun_r     <= 4'h0;
      newSeq_r       <= 4'hf;
      tcFlag_r       <= 4'h0;
      reqPrev_r      <= 4'h0;
      waitSet_r      <= `WAIT_RESET;
      intStat_r      <= 4'h0;
      intMask_r      <= 4'h0;
      state_r        <= ST_IDLE;
      strobeCnt_r    <= 4'h0;
      regRdata_r     <= 32'h0000_0000;
      xferBusy_r     <= 1'b0;
      xferChannel_r  <= 2'h0;
      xferTwoCycle_r <= 1'b0;
      xferPhase_r    <= 1'b0;
      xferStrobe_r   <= 1'b0;
      xferLast_r     <= 1'b0;
      strobeWidth_r  <= `STROBE_8CLK;
      transferEndPulse_r <= 4'h0;
      irq_r          <= 1'b0;
    end else begin
      // defaults: pulses drop, read data stand one cycle only
      transferEndPulse_r <= 4'h0;
      regRdata_r <= 32'h0000_0000;
      reqPrev_r  <= periphXferReq;
      strobeWidth_r <= strobeNxt;
      irq_r <= |(intStat_r & intMask_r);

      // step mode arms on each new request edge
      for (j = 0; j < 4; j = j + 1) begin
        if (reqEdge[j])
          stepArm_r[j] <= 1'b1;
      end

      // transfer engine
      case (state_r)
        ST_IDLE: begin
          if (startOk) begin
            state_r        <= ST_RUN;
            xferBusy_r     <= 1'b1;
            xferStrobe_r   <= 1'b1;
            xferChannel_r  <= grantIdx;
            xferTwoCycle_r <= twoCycle_r[grantIdx];
            xferPhase_r    <= 1'b0;
            strobeCnt_r    <= 4'h1;
            xferLast_r     <= (remCount_r[grantIdx] == {COUNT_W{1'b0}});
            // one trigger or edge buys one transfer
            swTrig_r[grantIdx] <= 1'b0;
            if (!reqEdge[grantIdx])
              stepArm_r[grantIdx] <= 1'b0;
            // block runs to the end once started
            if (mode_r[grantIdx] == `DMA_MODE_BLOCK)
              blockRun_r[grantIdx] <= 1'b1;
          end
        end
        ST_RUN: begin
          if (abortRun || xferDone) begin
            state_r      <= ST_IDLE;
            xferBusy_r   <= 1'b0;
            xferStrobe_r <= 1'b0;
            xferPhase_r  <= 1'b0;
            xferLast_r   <= 1'b0;
            strobeCnt_r  <= 4'h0;
          end else if (strobeCnt_r >= strobeWidth_r) begin
            // 2-cycle: read phase over, start the write phase
            xferPhase_r <= 1'b1;
            strobeCnt_r <= 4'h1;
          end else begin
            strobeCnt_r <= strobeCnt_r + 4'h1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase

      // register writes
      if (regWrite) begin
        if (ctrlHit) begin
          mode_r[wordChan]     <= regWdata[`CTL_MODE_HI:`CTL_MODE_LO];
          twoCycle_r[wordChan] <= regWdata[`CTL_TWOCYC_BIT];
          if (regWdata[`CTL_SWTRIG_BIT])
            swTrig_r[wordChan] <= 1'b1;
          if (regWdata[`CTL_INIT_BIT]) begin
            enable_r[wordChan]   <= 1'b0;
            blockRun_r[wordChan] <= 1'b0;
            swTrig_r[wordChan]   <= 1'b0;
            stepArm_r[wordChan]  <= 1'b0;
            newSeq_r[wordChan]   <= 1'b1;
            remCount_r[wordChan] <= progCount_r[wordChan];
          end else begin
            enable_r[wordChan] <= regWdata[`CTL_ENABLE_BIT];
            // rewrite of a set bit reloads nothing
            if (regWdata[`CTL_ENABLE_BIT] && !enable_r[wordChan] && newSeq_r[wordChan]) begin
              remCount_r[wordChan] <= progCount_r[wordChan];
              newSeq_r[wordChan]   <= 1'b0;
            end
          end
        end else if (countHit) begin
          progCount_r[wordChan] <= regWdata[COUNT_W-1:0];
        end else if (regAddr == `DMA_RESTART_ADDR) begin
          for (j = 0; j < 4; j = j + 1) begin
            enable_r[j] <= regWdata[j];
            if (regWdata[j] && !enable_r[j] && newSeq_r[j]) begin
              remCount_r[j] <= progCount_r[j];
              newSeq_r[j]   <= 1'b0;
            end
          end
        end else if (regAddr == `DMA_WAIT_ADDR) begin
          waitSet_r <= regWdata[7:0];
        end else if (regAddr == `DMA_STAT_ADDR) begin
          intStat_r <= intStat_r & ~regWdata[3:0];
        end else if (regAddr == `DMA_MASK_ADDR) begin
          intMask_r <= regWdata[3:0];
        end
      end

      // register reads
      if (regRead) begin
        regRdata_r <= readNxt;
        if (ctrlHit)
          tcFlag_r[wordChan] <= 1'b0;
      end

      // completion comes last so a terminal event beats any clear
      if (xferDone) begin
        if (remCount_r[xferChannel_r] == {COUNT_W{1'b0}}) begin
          enable_r[xferChannel_r]   <= 1'b0;
          blockRun_r[xferChannel_r] <= 1'b0;
          newSeq_r[xferChannel_r]   <= 1'b1;
          remCount_r[xferChannel_r] <= progCount_r[xferChannel_r];
          // set wins over same-cycle read clear
          tcFlag_r[xferChannel_r] <= 1'b1;
          intStat_r[xferChannel_r] <= 1'b1;
          transferEndPulse_r[xferChannel_r] <= 1'b1;
        end else begin
          remCount_r[xferChannel_r] <= remCount_r[xferChannel_r] - {{(COUNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // four_channel_dma_control

/* core/four_channel_dma_control_defines.vh */
// register map, field layout and reset values of the four-channel dma control block
`ifndef FOUR_CHANNEL_DMA_CONTROL_DEFINES_VH
`define FOUR_CHANNEL_DMA_CONTROL_DEFINES_VH

// byte addresses; control and count words are four apart per channel
`define DMA_CTRL_BASE    8'h00
`define DMA_COUNT_BASE   8'h10
`define DMA_RESTART_ADDR 8'h20
`define DMA_WAIT_ADDR    8'h24
`define DMA_STAT_ADDR    8'h28
`define DMA_MASK_ADDR    8'h2c
`define DMA_CHAN_MASK    8'hf3

// control register fields
`define CTL_ENABLE_BIT   0
`define CTL_INIT_BIT     1
`define CTL_SWTRIG_BIT   2
`define CTL_MODE_LO      3
`define CTL_MODE_HI      4
`define CTL_TWOCYC_BIT   5
`define CTL_TC_BIT       7

// transfer modes
`define DMA_MODE_SINGLE  2'h0
`define DMA_MODE_STEP    2'h1
`define DMA_MODE_BLOCK   2'h2

// system wait setting codes and strobe widths in clocks
`define WAIT_RESET       8'h77
`define WAIT_CODE_2CLK   8'h11
`define WAIT_CODE_3CLK   8'h12
`define WAIT_CODE_4CLK   8'h13
`define WAIT_CODE_5CLK   8'h14
`define WAIT_CODE_8CLK   8'h77
`define STROBE_2CLK      4'h2
`define STROBE_3CLK      4'h3
`define STROBE_4CLK      4'h4
`define STROBE_5CLK      4'h5
`define STROBE_8CLK      4'h8

`endif

/* tb/dma_ctl_chk.sv */
// port checker for the four-channel dma control block
`timescale 1ns/10ps
module dma_ctl_chk #(
  parameter COUNT_W = 16
) (
  input wire        sys_clk,
  input wire        reset_n,
  input wire [7:0]  regAddr,
  input wire [31:0] regWdata,
  input wire        regWrite,
  input wire        regRead,
  input wire [31:0] regRdata_r,
  input wire [3:0]  periphXferReq,
  input wire        xferBusy_r,
  input wire [1:0]  xferChannel_r,
  input wire        xferTwoCycle_r,
  input wire        xferPhase_r,
  input wire        xferStrobe_r,
  input wire        xferLast_r,
  input wire [3:0]  strobeWidth_r,
  input wire [3:0]  transferEndPulse_r,
  input wire        irq_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  reg [5:0] stbRun_r;  // strobe length so far
  // judged when the strobe drops; a drop right after an init write is left out, since an abort cuts it short
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      stbRun_r <= 6'h0;
    else
      stbRun_r <= xferStrobe_r ? stbRun_r + 6'h1 : 6'h0;
  end
  // unknown codes fall back to the slowest strobe
  function [3:0] wdec(input [31:0] c);
    case (c[7:0])
      8'h11: wdec = 4'h2;
      8'h12: wdec = 4'h3;
      8'h13: wdec = 4'h4;
      8'h14: wdec = 4'h5;
      default: wdec = 4'h8;
    endcase
  endfunction
  chk_wait_decode: assert property ((regWrite && regAddr == 8'h24) |->
    ##2 strobeWidth_r == wdec($past(regWdata, 2))) else $error("strobe width does not follow wait code");
  chk_strobe_len: assert property (($fell(xferStrobe_r) && !$past(regWrite && regWdata[1])) |->
    stbRun_r == ($past(xferTwoCycle_r) ? {1'b0, $past(strobeWidth_r), 1'b0} : {2'h0, $past(strobeWidth_r)}))
    else $error("strobe length wrong");
  chk_flyby_phase: assert property ((xferBusy_r && !xferTwoCycle_r) |-> !xferPhase_r)
    else $error("flyby transfer shows write phase");
  chk_end_cause: assert property ((transferEndPulse_r != 4'h0) |->
    $past(xferBusy_r) && $past(xferLast_r)) else $error("end pulse without final transfer");
  chk_no_extra: assert property ($rose(xferBusy_r) |->
    ($past(transferEndPulse_r) & (4'h1 << xferChannel_r)) == 4'h0)
    else $error("channel restarted right after its end");
  chk_rdata_slot: assert property ((regRdata_r != 32'h0) |-> $past(regRead))
    else $error("read data outside its slot");
  chk_unmapped_zero: assert property (($past(regRead) && $past(regAddr) > 8'h2c) |->
    regRdata_r == 32'h0) else $error("unmapped read not zero");
  chk_tc_clear: assert property ((regRead && regAddr == 8'h00) ##1 regRdata_r[7]
    ##1 (regRead && regAddr == 8'h00) |=> !regRdata_r[7]) else $error("terminal flag survived a read");
  cov_end: cover property (transferEndPulse_r != 4'h0);
  cov_two_cycle: cover property (xferStrobe_r && xferPhase_r);
  cov_irq: cover property ($rose(irq_r));
endmodule // dma_ctl_chk
bind four_channel_dma_control dma_ctl_chk #(.COUNT_W(COUNT_W)) u_dma_ctl_chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata_r(regRdata_r),
  .periphXferReq(periphXferReq), .xferBusy_r(xferBusy_r), .xferChannel_r(xferChannel_r),
  .xferTwoCycle_r(xferTwoCycle_r), .xferPhase_r(xferPhase_r), .xferStrobe_r(xferStrobe_r), .xferLast_r(xferLast_r),
  .strobeWidth_r(strobeWidth_r), .transferEndPulse_r(transferEndPulse_r), .irq_r(irq_r));

/* tb/dma_far_side.sv */
// far-side model: request lines and a tally of transfers per channel
`timescale 1ns/10ps
module dma_far_side (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire [3:0]  reqOn,
  input  wire        xferStrobe_r,
  input  wire [1:0]  xferChannel_r,
  output wire [3:0]  periphXferReq,
  output reg  [31:0] tally_r
);
  reg stbPrev_r;  // strobe one cycle ago
  assign periphXferReq = reqOn;
  // one rise is one transfer; a 2-cycle pair holds the strobe high throughout
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stbPrev_r <= 1'b0;
      tally_r   <= 32'h0;
    end else begin
      stbPrev_r <= xferStrobe_r;
      if (xferStrobe_r && !stbPrev_r)
        tally_r[xferChannel_r*8 +: 8] <= tally_r[xferChannel_r*8 +: 8] + 8'h1;
    end
  end
endmodule // dma_far_side

/* tb/four_channel_dma_control_tb.sv */
// self-checking bench for the four-channel dma control block
`timescale 1ns/10ps
module four_channel_dma_control_tb;
  reg         sys_clk   = 1'b0;
  reg         reset_n   = 1'b0;
  reg  [7:0]  regAddr   = 8'h0;
  reg  [31:0] regWdata  = 32'h0;
  reg         regWrite  = 1'b0;
  reg         regRead   = 1'b0;
  reg  [3:0]  reqOn     = 4'h0;
  reg  [15:0] endCnt    = 16'h0;  // end pulses seen per channel
  reg  [31:0] rdv;
  reg  [47:0] waitCodes = 48'h11_14_13_12_15_77;  // wait codes, first in the low byte
  reg  [23:0] waitClk   = 24'h2_5_4_3_8_8;        // strobe clocks expected for each code
  wire [31:0] regRdata_r, tally_r;
  wire [3:0]  periphXferReq, strobeWidth_r, transferEndPulse_r;
  wire [1:0]  xferChannel_r;
  wire        xferBusy_r, xferTwoCycle_r, xferPhase_r, xferStrobe_r, xferLast_r, irq_r;
  integer     n_fail = 0, cmp_count = 0, i, j;
  four_channel_dma_control #(.COUNT_W(16)) u_four_channel_dma_control (.sys_clk, .reset_n, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata_r, .periphXferReq, .xferBusy_r, .xferChannel_r,
    .xferTwoCycle_r, .xferPhase_r, .xferStrobe_r, .xferLast_r, .strobeWidth_r, .transferEndPulse_r, .irq_r);
  dma_far_side u_dma_far_side (.sys_clk, .reset_n, .reqOn, .xferStrobe_r, .xferChannel_r, .periphXferReq, .tally_r);
  always #4 sys_clk = ~sys_clk;
  // count pulses so a pulse during a register write is never missed
  always @(posedge sys_clk)
    for (j = 0; j < 4; j = j + 1)
      if (transferEndPulse_r[j] === 1'b1) endCnt[j*4 +: 4] <= endCnt[j*4 +: 4] + 4'h1;
  function [31:0] ctl(input en, input sw, input [1:0] md, input two);
    ctl = {26'h0, two, md, sw, 1'b0, en};
  endfunction
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWrite <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [7:0] a);
    begin
      @(posedge sys_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1 rdv = regRdata_r;
    end
  endtask
  // bounded wait for the n-th end pulse of a channel
  task wait_end(input [1:0] ch, input [3:0] n);
    integer k;
    begin
      for (k = 0; k < 300 && endCnt[ch*4 +: 4] !== n; k = k + 1)
        @(posedge sys_clk);
      if (k == 300) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t end pulse missing", $time);
        close_out;
      end else begin
        repeat (3) @(posedge sys_clk);
      end
    end
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    cmp({28'h0, strobeWidth_r}, 32'h8);
    rd(8'h24);
    cmp(rdv, 32'h77);
    rd(8'h30);
    cmp(rdv, 32'h0);
    // the table ends on the 2-clock code, the fast setting software picks
    for (i = 0; i < 6; i = i + 1) begin
      wr(8'h24, {24'h0, waitCodes[i*8 +: 8]});
      repeat (3) @(posedge sys_clk);
      cmp({28'h0, strobeWidth_r}, {28'h0, waitClk[i*4 +: 4]});
    end
    $display("test wait decode done");
    wr(8'h2c, 32'h1);
    wr(8'h10, 32'h1);
    wr(8'h00, ctl(1, 0, 2, 0));
    wr(8'h00, ctl(0, 0, 2, 0));
    wr(8'h00, ctl(1, 1, 2, 0));
    wr(8'h00, ctl(1, 0, 2, 0));
    wait_end(0, 1);
    cmp(tally_r, 32'h2);
    rd(8'h00);
    cmp(rdv & 32'h81, 32'h80);
    rd(8'h00);
    cmp(rdv & 32'h80, 32'h0);
    rd(8'h00);
    cmp(rdv & 32'h80, 32'h0);
    rd(8'h10);
    cmp(rdv, 32'h0001_0001);
    rd(8'h28);
    cmp(rdv, 32'h1);
    cmp({31'h0, irq_r}, 32'h1);
    wr(8'h28, 32'h1);
    repeat (2) @(posedge sys_clk);
    cmp({31'h0, irq_r}, 32'h0);
    $display("test block flyby done");
    wr(8'h14, 32'h0);
    wr(8'h04, ctl(1, 0, 0, 1));
    @(posedge sys_clk) reqOn <= 4'h2;
    wait_end(1, 1);
    reqOn <= 4'h0;
    cmp(tally_r, 32'h0102);
    rd(8'h28);
    cmp(rdv, 32'h2);
    cmp({31'h0, irq_r}, 32'h0);
    wr(8'h2c, 32'h3);
    repeat (2) @(posedge sys_clk);
    cmp({31'h0, irq_r}, 32'h1);
    wr(8'h28, 32'h2);
    $display("test two-cycle request done");
    wr(8'h18, 32'h3);
    wr(8'h08, ctl(1, 1, 0, 0));
    repeat (12) @(posedge sys_clk);
    cmp(tally_r, 32'h01_0102);
    wr(8'h08, 32'h2);
    repeat (4) @(posedge sys_clk);
    rd(8'h08);
    cmp(rdv & 32'h83, 32'h0);
    rd(8'h28);
    cmp(rdv, 32'h0);
    rd(8'h18);
    cmp(rdv, 32'h0003_0003);
    // enable is touched again only after the forced termination
    wr(8'h08, ctl(1, 1, 2, 0));
    wait_end(2, 1);
    cmp(tally_r, 32'h05_0102);
    $display("test initialise done");
    wr(8'h1c, 32'h1);
    wr(8'h0c, ctl(1, 0, 1, 0));
    @(posedge sys_clk) reqOn <= 4'h8;
    repeat (12) @(posedge sys_clk) reqOn <= 4'h0;
    wr(8'h20, 32'h0);
    @(posedge sys_clk) reqOn <= 4'h8;
    repeat (12) @(posedge sys_clk) reqOn <= 4'h0;
    cmp(tally_r, 32'h0105_0102);
    wr(8'h20, 32'h8);
    @(posedge sys_clk) reqOn <= 4'h8;
    wait_end(3, 1);
    reqOn <= 4'h0;
    cmp(tally_r, 32'h0205_0102);
    $display("test step restart done");
    // two channels finish back to back, then each flag must clear on its own read
    wr(8'h10, 32'h0);
    wr(8'h00, ctl(1, 1, 2, 0));
    wr(8'h04, ctl(1, 1, 2, 0));
    wait_end(1, 2);
    cmp(tally_r, 32'h0205_0203);
    for (i = 0; i < 4; i = i + 1) begin
      rd({5'h0, i[0], 2'h0});
      cmp(rdv & 32'h80, (i < 2) ? 32'h80 : 32'h0);
    end
    $display("test two channels done");
    close_out;
  end
endmodule // four_channel_dma_control_tb
